// [logic/wric_ctrl.v]
// Purpose: Wake-up and interrupt-enable control
// Assumes: Events are one-cycle pulses synchronous to clk; ports are ORed per group
// Notes:   Register writes come from dedicated instructions on op/op_data
`include "wric_map.vh"

module wric_ctrl (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Instruction port
  input  wire [2:0] op,
  input  wire [7:0] op_data,
  // Power mode control
  input  wire       halt_cmd,
  input  wire       stop_cmd,
  input  wire       chatter_mode,
  input  wire       irq_ack,
  input  wire [2:0] irq_ack_num,
  // Wake sources
  input  wire [3:0] port_a,
  input  wire [3:0] port_c,
  input  wire [3:0] port_d,
  input  wire       extint_pin,
  input  wire       timer_one_uf,
  input  wire       timer_two_uf,
  input  wire       timer_three_uf,
  input  wire       prediv_ovf,
  input  wire       keyscan_end,
  input  wire       key_high,
  input  wire       rfc_end,
  // Status outputs
  output reg        halt_release,
  output reg        stop_release,
  output reg        in_halt,
  output reg        in_stop,
  output reg  [7:0] irq_req,
  output reg  [2:0] port_start_flags,
  output reg  [7:0] wake_request
);

  localparam RUN  = 2'h0;
  localparam HALT = 2'h1;
  localparam STOP = 2'h2;

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [5:0] port_wake_enable_reg;
  reg  [7:0] halt_wake_enable_reg;
  reg  [7:0] interrupt_enable_reg;
  reg  [2:0] stop_release_enable_reg;
  reg  [2:0] or_prev_reg;
  reg        extint_prev_reg;
  reg        pending_stop_reg;
  reg  [2:0] start_set;
  reg  [7:0] req_set;
  reg        wake_any;

  wire [2:0] port_or;
  wire [2:0] deb_or;
  wire [2:0] port_en;
  wire [2:0] stop_en;
  wire       extint_edge;
  wire       ack_port;

  assign port_or = {|port_a, |port_c, |port_d};
  assign port_en = {port_wake_enable_reg[`WRIC_PWE_A], port_wake_enable_reg[`WRIC_PWE_C],
                    port_wake_enable_reg[`WRIC_PWE_D]};
  assign stop_en = stop_release_enable_reg;
  assign extint_edge = extint_pin ^ extint_prev_reg;
  assign ack_port = irq_ack && (irq_ack_num == 3'h0);

  // One debouncer per port group
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : deb
      wric_debounce u_deb (
        .clk        (clk),
        .rst        (rst),
        .sig_in     (port_or[g]),
        .sig_stable (deb_or[g])
      );
    end
  endgenerate

  // Start conditions per port group
  always @* begin
    start_set = 3'h0;
    if (chatter_mode == `WRIC_MODE_LEVEL) begin
      start_set = port_en & port_or & ~or_prev_reg;
    end else if (state_reg != STOP) begin
      start_set = port_en & (deb_or ^ or_prev_reg);
      if (pending_stop_reg) begin
        start_set = port_en & stop_en & deb_or & ~or_prev_reg;
      end
    end
  end

  // Request set terms; STOP blocks everything but INT, key_high and, in level mode only, port
  always @* begin
    req_set    = 8'h00;
    req_set[0] = |start_set;
    req_set[2] = extint_edge && (halt_wake_enable_reg[2] || interrupt_enable_reg[2]);
    if (state_reg == STOP) begin
      req_set[5] = key_high && (halt_wake_enable_reg[5] || interrupt_enable_reg[5]);
    end else begin
      req_set[1] = timer_one_uf;
      req_set[3] = prediv_ovf;
      req_set[4] = timer_two_uf;
      req_set[5] = (keyscan_end || key_high);
      req_set[6] = rfc_end;
      req_set[7] = timer_three_uf;
    end
    // Wake needs a halt enable or an interrupt enable on that source, or a port start
    wake_any = |(req_set & (halt_wake_enable_reg | interrupt_enable_reg)) || |start_set;
  end

  // State machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      RUN: begin
        if (stop_cmd && !(|(port_en & port_or))) begin
          state_next = STOP;
        end else if (halt_cmd && !(|wake_request) &&
                     !(chatter_mode == `WRIC_MODE_LEVEL && |(port_en & port_or))) begin
          state_next = HALT;
        end
      end
      HALT: begin
        if (pending_stop_reg && !(|(port_en & port_or))) begin
          state_next = STOP;
        end else if (wake_any || |(irq_req & ~8'h00)) begin
          state_next = RUN;
        end
      end
      STOP: begin
        if (chatter_mode == `WRIC_MODE_CHATTER && |(port_en & stop_en & port_or)) begin
          state_next = HALT;
        end else if (wake_any) begin
          state_next = RUN;
        end
      end
      default: state_next = RUN;
    endcase
  end

  integer i;
  always @(posedge clk) begin
    if (rst) begin
      state_reg               <= RUN;
      port_wake_enable_reg    <= `WRIC_PWE_RST;
      halt_wake_enable_reg    <= `WRIC_HWE_RST;
      interrupt_enable_reg    <= `WRIC_IEN_RST;
      stop_release_enable_reg <= `WRIC_SRE_RST;
      or_prev_reg             <= 3'h0;
      extint_prev_reg         <= 1'b0;
      pending_stop_reg        <= 1'b0;
      halt_release            <= 1'b0;
      stop_release            <= 1'b0;
      in_halt                 <= 1'b0;
      in_stop                 <= 1'b0;
      irq_req                 <= 8'h00;
      port_start_flags        <= 3'h0;
      wake_request            <= 8'h00;
    end else begin
      state_reg       <= state_next;
      extint_prev_reg <= extint_pin;
      or_prev_reg     <= (chatter_mode == `WRIC_MODE_CHATTER) ? deb_or : port_or;
      in_halt         <= (state_next == HALT);
      in_stop         <= (state_next == STOP);
      stop_release    <= (state_reg == STOP) && (state_next != STOP);
      halt_release    <= (state_reg == HALT) && (state_next == RUN);
      if (state_reg == STOP && state_next == HALT) begin
        pending_stop_reg <= 1'b1;
      end else if (|start_set || state_next != HALT) begin
        pending_stop_reg <= 1'b0;
      end
      // Register writes
      case (op)
        `WRIC_OP_PORT_WAKE: port_wake_enable_reg <= op_data[5:0] & `WRIC_PWE_MASK;
        `WRIC_OP_HALT_EN:   halt_wake_enable_reg <= op_data & `WRIC_HWE_MASK;
        `WRIC_OP_IRQ_EN:    interrupt_enable_reg <= op_data;
        `WRIC_OP_STOP_EN:   stop_release_enable_reg <= {op_data[`WRIC_SRE_A],
                                op_data[`WRIC_SRE_C], op_data[`WRIC_SRE_D]};
        default: ;
      endcase
      if (ack_port) begin
        port_wake_enable_reg <= `WRIC_PWE_RST;
      end
      if (irq_ack) begin
        interrupt_enable_reg[irq_ack_num] <= 1'b0;
      end
      // Start flags: rewrite of port enables clears, set wins
      for (i = 0; i < 3; i = i + 1) begin
        if (start_set[i]) begin
          port_start_flags[i] <= 1'b1;
        end else if (op == `WRIC_OP_PORT_WAKE) begin
          port_start_flags[i] <= 1'b0;
        end
      end
      // Requests: set wins over clear by ack or clear op
      for (i = 0; i < 8; i = i + 1) begin
        if (req_set[i]) begin
          wake_request[i] <= 1'b1;
        end else if ((irq_ack && irq_ack_num == i[2:0]) ||
                     (op == `WRIC_OP_CLR_REQ && op_data[i])) begin
          wake_request[i] <= 1'b0;
        end
        irq_req[i] <= (wake_request[i] | req_set[i]) & interrupt_enable_reg[i] &
                      !(irq_ack && irq_ack_num == i[2:0]);
      end
    end
  end

endmodule

// [shared/wric_map.vh]
// Purpose: Constants for the wake-up and interrupt-enable controller
// Assumes: Opcode values and bit positions below are shared by all design files
// Notes:   Instruction operand is 8 bits; unused bits are ignored
`ifndef WRIC_MAP_VH
`define WRIC_MAP_VH

// Instruction op codes on the op port
`define WRIC_OP_NONE        3'h0
`define WRIC_OP_PORT_WAKE   3'h1
`define WRIC_OP_HALT_EN     3'h2
`define WRIC_OP_IRQ_EN      3'h3
`define WRIC_OP_STOP_EN     3'h4
`define WRIC_OP_CLR_REQ     3'h5

// Port wake-enable field positions
`define WRIC_PWE_A          5
`define WRIC_PWE_C          4
`define WRIC_PWE_D          3
`define WRIC_PWE_MASK       6'h38

// Stop-release enable positions
`define WRIC_SRE_A          6
`define WRIC_SRE_C          4
`define WRIC_SRE_D          3

// Halt-release enable valid bits (1..5 and 7)
`define WRIC_HWE_MASK       8'hbe

// Reset values
`define WRIC_PWE_RST        6'h00
`define WRIC_HWE_RST        8'h00
`define WRIC_IEN_RST        8'h00
`define WRIC_SRE_RST        3'h0

// Debounce interval, in ns, and derived cycle count at 100 MHz
`define WRIC_DEBOUNCE_NS    1000
`define WRIC_CLK_NS         10
`define WRIC_DEBOUNCE_CYC   (`WRIC_DEBOUNCE_NS / `WRIC_CLK_NS)

// Modes
`define WRIC_MODE_LEVEL     1'b0
`define WRIC_MODE_CHATTER   1'b1

`endif

// [logic/wric_debounce.v]
// Purpose: Debounce one port-group OR signal
// Assumes: Input synchronous to clk
// Notes:   Output follows input once stable for the full interval
`include "wric_map.vh"

module wric_debounce (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Signal
  input  wire       sig_in,
  output reg        sig_stable
);

  reg [7:0] cnt_reg;

  always @(posedge clk) begin
    if (rst) begin
      cnt_reg    <= 8'h00;
      sig_stable <= 1'b0;
    end else if (sig_in == sig_stable) begin
      cnt_reg <= 8'h00;
    end else if ({24'h000000, cnt_reg} == (`WRIC_DEBOUNCE_CYC - 1)) begin
      cnt_reg    <= 8'h00;
      sig_stable <= sig_in;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

endmodule

// [tb/wric_ctrl_assertions.sv]
// Purpose: Port-level checks for the wake and interrupt controller
// Assumes: One clock, synchronous active-high reset
// Notes:   Port D wake enable is write-only, so it is tracked here
`include "wric_map.vh"
module wric_ctrl_chk (
  // Clock and reset
  input logic       clk,
  input logic       rst,
  // Inputs watched
  input logic [2:0] op,
  input logic [7:0] op_data,
  input logic       halt_cmd,
  input logic       chatter_mode,
  input logic       irq_ack,
  input logic [2:0] irq_ack_num,
  input logic [3:0] port_d,
  // Outputs watched
  input logic       halt_release,
  input logic       stop_release,
  input logic       in_halt,
  input logic       in_stop,
  input logic [7:0] irq_req,
  input logic [2:0] port_start_flags,
  input logic [7:0] wake_request
);
  logic pwe_d_reg;
  // Port accept drops the enable, like the device does
  always @(posedge clk)
    if (rst || (irq_ack && irq_ack_num == 3'h0)) pwe_d_reg <= 1'b0;
    else if (op == `WRIC_OP_PORT_WAKE) pwe_d_reg <= op_data[`WRIC_PWE_D];

  chk_halt_pulse: assert property (@(posedge clk) disable iff (rst)
    halt_release |=> !halt_release) else $error("halt release longer than one cycle");
  chk_stop_pulse: assert property (@(posedge clk) disable iff (rst)
    stop_release |=> !stop_release) else $error("stop release longer than one cycle");
  chk_halt_refused: assert property (@(posedge clk) disable iff (rst)
    (halt_cmd && !in_halt && wake_request != 8'h00) |=> !in_halt)
    else $error("halt entered with request pending");
  chk_level_halt: assert property (@(posedge clk) disable iff (rst)
    (halt_cmd && !in_halt && !chatter_mode && pwe_d_reg && |port_d) |=> !in_halt)
    else $error("halt entered with enabled port high");
  chk_level_flag: assert property (@(posedge clk) disable iff (rst)
    (!chatter_mode && pwe_d_reg && $rose(|port_d)) |=> port_start_flags[0] && wake_request[0])
    else $error("port D rise not flagged");
  chk_ack_clear: assert property (@(posedge clk) disable iff (rst)
    (irq_ack && irq_ack_num == 3'h2) |=> !irq_req[2]) else $error("accepted irq not cleared");
  chk_irq_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_req[2]) |-> wake_request[2] || $past(wake_request[2]))
    else $error("irq without request");
  chk_halt_exit: assert property (@(posedge clk) disable iff (rst)
    ($fell(in_halt) && !in_stop) |-> ##[0:1] halt_release)
    else $error("halt left without release");

  cover property (@(posedge clk) halt_release);
  cover property (@(posedge clk) stop_release);
  cover property (@(posedge clk) port_start_flags[0]);
endmodule

bind wric_ctrl wric_ctrl_chk u_chk (.clk, .rst, .op, .op_data, .halt_cmd, .chatter_mode,
  .irq_ack, .irq_ack_num, .port_d, .halt_release, .stop_release, .in_halt, .in_stop, .irq_req,
  .port_start_flags, .wake_request);

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the wake and interrupt controller
// Assumes: Level detection mode; ports A and C held low
// Notes:   Debounce path is left out, its timing is the designer's choice
`include "wric_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] op = 3'h0;
  logic [7:0] op_data = 8'h00;
  logic       halt_cmd = 1'b0;
  logic       stop_cmd = 1'b0;
  logic       irq_ack = 1'b0;
  logic [2:0] irq_ack_num = 3'h0;
  logic [3:0] port_d = 4'h0;
  logic       extint_pin = 1'b0;
  logic       key_high = 1'b0;
  logic [7:0] src = 8'h00;
  logic       halt_release, stop_release, in_halt, in_stop;
  logic [7:0] irq_req, wake_request;
  logic [2:0] port_start_flags;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         srcs[6] = '{1, 3, 4, 5, 7, 6};

  always #5 clk = ~clk;

  wric_ctrl dut (.clk, .rst, .op, .op_data, .halt_cmd, .stop_cmd, .chatter_mode(1'b0),
    .irq_ack, .irq_ack_num, .port_a(4'h0), .port_c(4'h0), .port_d, .extint_pin,
    .timer_one_uf(src[1]), .timer_two_uf(src[4]), .timer_three_uf(src[7]),
    .prediv_ovf(src[3]), .keyscan_end(src[5]), .key_high, .rfc_end(src[6]),
    .halt_release, .stop_release, .in_halt, .in_stop, .irq_req, .port_start_flags,
    .wake_request);

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_op(input logic [2:0] c, input logic [7:0] d);
    @(posedge clk);
    op <= c;
    op_data <= d;
    @(posedge clk);
    op <= `WRIC_OP_NONE;
  endtask

  task automatic cmd(input logic stop);
    @(posedge clk);
    {stop_cmd, halt_cmd} <= {stop, !stop};
    @(posedge clk);
    {stop_cmd, halt_cmd} <= 2'b00;
    #1;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 8'h00;
  endtask

  task automatic ack(input logic [2:0] n);
    @(posedge clk);
    irq_ack <= 1'b1;
    irq_ack_num <= n;
    @(posedge clk);
    irq_ack <= 1'b0;
    #1;
  endtask

  // Bounded wait; a release pulse lasts only one cycle
  task automatic wait_rel();
    int n;
    n = 0;
    #1;
    while (n < 10 && !(halt_release | stop_release)) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp({7'h0, halt_release | stop_release}, 8'h01);
  endtask

  task automatic t_port_level();
    do_op(`WRIC_OP_PORT_WAKE, 8'h08);
    @(posedge clk);
    port_d <= 4'h4;
    repeat (2) @(posedge clk);
    #1;
    cmp({5'h0, port_start_flags}, 8'h01);
    cmp({7'h0, wake_request[0]}, 8'h01);
    cmd(1'b0);
    cmp({7'h0, in_halt}, 8'h00);
    @(posedge clk);
    port_d <= 4'h0;
    do_op(`WRIC_OP_PORT_WAKE, 8'h00);
  endtask

  // Accepting the port interrupt must drop the port enables
  task automatic t_port_ack();
    do_op(`WRIC_OP_CLR_REQ, 8'hff);
    do_op(`WRIC_OP_PORT_WAKE, 8'h08);
    do_op(`WRIC_OP_IRQ_EN, 8'h01);
    @(posedge clk);
    port_d <= 4'h1;
    repeat (2) @(posedge clk);
    #1;
    cmp(irq_req, 8'h01);
    ack(3'h0);
    cmp(irq_req | wake_request, 8'h00);
    @(posedge clk);
    port_d <= 4'h0;
    repeat (2) @(posedge clk);
    port_d <= 4'h1;
    repeat (2) @(posedge clk);
    #1;
    cmp({7'h0, wake_request[0]}, 8'h00);
    @(posedge clk);
    port_d <= 4'h0;
  endtask

  task automatic t_halt_src(input int b);
    logic [7:0] m;
    m = 8'h01 << b;
    do_op(`WRIC_OP_CLR_REQ, 8'hff);
    do_op(`WRIC_OP_HALT_EN, b == 6 ? 8'h00 : m);
    do_op(`WRIC_OP_IRQ_EN, b == 6 ? m : 8'h00);
    cmd(1'b0);
    cmp({7'h0, in_halt}, 8'h01);
    pulse(m);
    wait_rel();
    cmp(wake_request & m, m);
    cmp({7'h0, in_halt}, 8'h00);
    cmp(irq_req, b == 6 ? m : 8'h00);
    ack(b[2:0]);
    cmp(irq_req, 8'h00);
  endtask

  task automatic t_extint();
    do_op(`WRIC_OP_CLR_REQ, 8'hff);
    do_op(`WRIC_OP_HALT_EN, 8'h04);
    do_op(`WRIC_OP_IRQ_EN, 8'h04);
    @(posedge clk);
    extint_pin <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp(irq_req & wake_request, 8'h04);
    ack(3'h2);
    cmp(irq_req | wake_request, 8'h00);
    @(posedge clk);
    extint_pin <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp(irq_req | wake_request, 8'h04);
  endtask

  task automatic t_stop_key();
    do_op(`WRIC_OP_CLR_REQ, 8'hff);
    do_op(`WRIC_OP_HALT_EN, 8'h22);
    cmd(1'b1);
    cmp({7'h0, in_stop}, 8'h01);
    pulse(8'h02);
    repeat (3) @(posedge clk);
    #1;
    cmp({6'h0, in_stop, stop_release}, 8'h02);
    @(posedge clk);
    key_high <= 1'b1; // Normal scan, no LCD timing in STOP
    @(posedge clk);
    key_high <= 1'b0;
    wait_rel();
    cmp(wake_request & 8'h20, 8'h20);
  endtask

  // Ceiling far above the roughly 130 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_port_level();
    t_port_ack();
    foreach (srcs[i]) t_halt_src(srcs[i]);
    t_extint();
    t_stop_key();
    tally_and_finish();
  end
endmodule
